/* File: design/dtm_params.svh */
// constants for the drive terminal io mapping block
`ifndef DTM_PARAMS_SVH
`define DTM_PARAMS_SVH
`define DTM_CLK_HZ          125000000
`define DTM_CLK_PERIOD_NS   8
`define DTM_TENTH_S_NS      100000000
`define DTM_TENTH_CYCLES    (`DTM_TENTH_S_NS / `DTM_CLK_PERIOD_NS)
`define DTM_SEQ_PULSE_MS    250
`define DTM_SEQ_CYCLES      (`DTM_SEQ_PULSE_MS * 1000000 / `DTM_CLK_PERIOD_NS)
`define DTM_PULSE_MAX_HZ    50000
`define DTM_MIN_HALF        ((`DTM_CLK_HZ + 2 * `DTM_PULSE_MAX_HZ - 1) / (2 * `DTM_PULSE_MAX_HZ))
`define DTM_DELAY_MAX       16'h8CA0
`define DTM_NUM_SEL         14
`define DTM_OFS_POL_A       6'h00
`define DTM_OFS_POL_B       6'h04
`define DTM_OFS_MODE        6'h08
`define DTM_OFS_OC_SEL      6'h0C
`define DTM_OFS_RELAY_SEL   6'h10
`define DTM_OFS_EXT_SEL     6'h14
`define DTM_OFS_DELAY1      6'h18
`define DTM_OFS_DELAY2      6'h1C
`define DTM_OFS_DELAY3      6'h20
`define DTM_OFS_HALF        6'h24
`define DTM_OFS_STATUS      6'h28
`define DTM_RST_POL_A       20'h0_0000
`define DTM_RST_POL_B       4'h0
`define DTM_RST_OC_SEL      8'h00
`define DTM_RST_RELAY_SEL   8'h02
`define DTM_RST_EXT_SEL     8'h00
`define DTM_RST_DELAY       16'h0000
`define DTM_RST_HALF        16'h0000
`endif

/* File: design/dtm_pkg.sv */
// types for the drive terminal io mapping block
package dtm_pkg;
   typedef enum logic {DTM_MODE_PULSE, DTM_MODE_OC} dtm_mode_type;
   typedef logic [7:0] dtm_sel_type;
endpackage

/* File: design/dtm_input_delay.sv */
// state-change delay for one switch input
`timescale 1ns/1ps
`include "dtm_params.svh"
module dtm_input_delay
   import dtm_pkg::*;
#(
   parameter int DW = 16
)
(
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire logic          level_i,
   input  wire logic          tick_i,
   input  wire logic [DW-1:0] delay_i,
   output logic               level_o
);
   logic [DW-1:0] cnt;
   logic          held;

   generate
      if (DW < 16)
      begin : g_chk
         $error("delay width too small");
      end
   endgenerate

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         held <= 1'b0;
         cnt  <= '0;
      end
      else if (level_i == held)
      begin
         cnt <= '0;
      end
      else if (delay_i == '0 || (tick_i && cnt + 1'b1 >= delay_i)) // RQ21
      begin
         held <= level_i;
         cnt  <= '0;
      end
      else if (tick_i)
      begin
         cnt <= cnt + 1'b1; // RQ21
      end
   end

   assign level_o = held;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_zero_delay_pass: assert property ( // RQ21
      (delay_i == '0 && level_i != held) |=> held == $past(level_i))
      else $error("zero delay did not pass change");
   a_change_needs_tick: assert property ( // RQ21
      (delay_i > 1 && $stable(delay_i) && level_i != held && !tick_i) |=> $stable(held))
      else $error("change taken without delay tick");
endmodule

/* File: design/dtm_terminal_map.sv */
// drive terminal io mapping top
`timescale 1ns/1ps
`include "dtm_params.svh"
// Functional notes
// RQ1: polarity 0: input active while tied to return, inactive while open.
// RQ2: polarity 1: sense inverted, tied to return means inactive.
// RQ3: polarity word a, five digits, units to ten-thousands map inputs one to five.
// RQ4: polarity word b units digit is input six; upper digits reserved; resets zero.
// RQ5: only inputs one to three apply the state-change delay.
// RQ6: shared terminal mode 0 pulse train (default), 1 open-collector switch.
// RQ7: pulse train frequency never above 50 kHz.
// RQ8: each output has own selector; relay defaults 2, open-collector 0.
// RQ9: selector 0 keeps output inactive.
// RQ10: selector 1 active while running, also at zero frequency.
// RQ11: selector 2 active when stopped by fault.
// RQ12: selector 3 frequency level flag one, selector 4 frequency reached.
// RQ13: selector 5 active running at zero frequency, off when stopped.
// RQ14: selector 6 motor overload pre-warning.
// RQ15: selector 7 drive overload warning 10 s ahead of protection.
// RQ16: selector 8 preset count reached, selector 9 intermediate count reached.
// RQ17: selector 10 actual length exceeds length target.
// RQ18: selector 11 single 250 ms pulse per sequencer cycle.
// RQ19: selector 12 accumulated running time beyond threshold.
// RQ20: selector 13 set frequency beyond limit and output at limit.
// RQ21: delayed inputs hold off changes 0 to 3600 s in 0.1 s steps.
// RQ22: outputs registered, follow condition or selector on next edge.
// RQ23: undefined selectors drive the output inactive.
module dtm_terminal_map
   import dtm_pkg::*;
#(
   parameter int TENTH_CYCLES = `DTM_TENTH_CYCLES,
   parameter int SEQ_CYCLES   = `DTM_SEQ_CYCLES,
   parameter int NUM_IN       = 6
)
(
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic [5:0]        avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic [NUM_IN-1:0] switch_input_i,
   output logic      [NUM_IN-1:0] recognised_input_o,
   input  wire logic              run_i,
   input  wire logic              fault_stop_i,
   input  wire logic              freq_level_flag_one_i,
   input  wire logic              freq_reached_i,
   input  wire logic              zero_freq_i,
   input  wire logic              motor_overload_prewarn_i,
   input  wire logic              drive_overload_10s_i,
   input  wire logic              preset_count_reached_i,
   input  wire logic              intermediate_count_reached_i,
   input  wire logic              length_exceeded_i,
   input  wire logic              step_sequencer_cycle_done_i,
   input  wire logic              run_time_exceeded_i,
   input  wire logic              set_freq_beyond_limit_i,
   input  wire logic              out_freq_at_limit_i,
   output logic                   main_relay_o,
   output logic                   extension_relay_two_o,
   output logic                   shared_output_terminal_o
);
   localparam logic [15:0] MIN_HALF = 16'(`DTM_MIN_HALF);

   logic [19:0]       input_polarity_word_a;
   logic [3:0]        input_polarity_word_b;
   dtm_mode_type      shared_terminal_mode_sel;
   dtm_sel_type       oc_output_function_sel;
   dtm_sel_type       relay_function_sel;
   dtm_sel_type       extension_relay_function_sel;
   logic [15:0]       delay_time [3];
   logic [15:0]       pulse_half_period;
   logic              ack;
   logic              wr_go;
   logic [31:0]       next_readdata;
   logic [15:0]       wr_delay;
   logic [NUM_IN-1:0] sync1;
   logic [NUM_IN-1:0] sync2;
   logic [NUM_IN-1:0] polarity;
   logic [NUM_IN-1:0] active;
   logic [31:0]       tenth_cnt;
   logic              tick;
   logic [31:0]       seq_cnt;
   logic [`DTM_NUM_SEL-1:0] cond;
   logic              next_main;
   logic              next_ext;
   logic              next_oc_level;
   logic [15:0]       half_eff;
   logic [15:0]       pulse_cnt;
   logic              pulse_level;
   generate
      if (TENTH_CYCLES < 1 || SEQ_CYCLES < 1 || NUM_IN != 6)
      begin : g_chk
         $error("unsupported parameter value");
      end
   endgenerate
   // avalon slave, one wait cycle per access
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
   assign wr_go             = avs_write_i && ack;
   assign wr_delay          = (avs_writedata_i[15:0] > `DTM_DELAY_MAX) ?
                              `DTM_DELAY_MAX : avs_writedata_i[15:0];
   always_comb
   begin
      next_readdata = 32'h0000_0000;
      unique case (avs_address_i)
         `DTM_OFS_POL_A:     next_readdata[19:0] = input_polarity_word_a;
         `DTM_OFS_POL_B:     next_readdata[3:0]  = input_polarity_word_b;
         `DTM_OFS_MODE:      next_readdata[0]    = shared_terminal_mode_sel;
         `DTM_OFS_OC_SEL:    next_readdata[7:0]  = oc_output_function_sel;
         `DTM_OFS_RELAY_SEL: next_readdata[7:0]  = relay_function_sel;
         `DTM_OFS_EXT_SEL:   next_readdata[7:0]  = extension_relay_function_sel;
         `DTM_OFS_DELAY1:    next_readdata[15:0] = delay_time[0];
         `DTM_OFS_DELAY2:    next_readdata[15:0] = delay_time[1];
         `DTM_OFS_DELAY3:    next_readdata[15:0] = delay_time[2];
         `DTM_OFS_HALF:      next_readdata[15:0] = pulse_half_period;
         `DTM_OFS_STATUS:    next_readdata[11:0] = {next_oc_level, shared_output_terminal_o,
                                                    extension_relay_two_o, main_relay_o,
                                                    2'b00, recognised_input_o};
         default:            next_readdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         ack            <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end
      else
      begin
         ack <= (avs_read_i || avs_write_i) && !ack;
         if (avs_read_i && !ack)
         begin
            avs_readdata_o <= next_readdata;
         end
      end
   end
   // configuration words
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         input_polarity_word_a        <= `DTM_RST_POL_A; // RQ3
         input_polarity_word_b        <= `DTM_RST_POL_B; // RQ4
         shared_terminal_mode_sel     <= DTM_MODE_PULSE; // RQ6
         oc_output_function_sel       <= `DTM_RST_OC_SEL; // RQ8
         relay_function_sel           <= `DTM_RST_RELAY_SEL; // RQ8
         extension_relay_function_sel <= `DTM_RST_EXT_SEL;
         delay_time[0]                <= `DTM_RST_DELAY;
         delay_time[1]                <= `DTM_RST_DELAY;
         delay_time[2]                <= `DTM_RST_DELAY;
         pulse_half_period            <= `DTM_RST_HALF;
      end
      else if (wr_go)
      begin
         unique case (avs_address_i)
            `DTM_OFS_POL_A:     input_polarity_word_a <= avs_writedata_i[19:0]; // RQ3
            `DTM_OFS_POL_B:     input_polarity_word_b <= avs_writedata_i[3:0]; // RQ4
            `DTM_OFS_MODE:      shared_terminal_mode_sel <= dtm_mode_type'(avs_writedata_i[0]);
            `DTM_OFS_OC_SEL:    oc_output_function_sel <= avs_writedata_i[7:0];
            `DTM_OFS_RELAY_SEL: relay_function_sel <= avs_writedata_i[7:0];
            `DTM_OFS_EXT_SEL:   extension_relay_function_sel <= avs_writedata_i[7:0];
            `DTM_OFS_DELAY1:    delay_time[0] <= wr_delay; // RQ21
            `DTM_OFS_DELAY2:    delay_time[1] <= wr_delay; // RQ21
            `DTM_OFS_DELAY3:    delay_time[2] <= wr_delay; // RQ21
            `DTM_OFS_HALF:      pulse_half_period <= avs_writedata_i[15:0];
            default:            ;
         endcase
      end
   end

   // polarity bit of each input: low bit of its decimal digit
   assign polarity = {input_polarity_word_b[0], input_polarity_word_a[16],
                      input_polarity_word_a[12], input_polarity_word_a[8],
                      input_polarity_word_a[4], input_polarity_word_a[0]}; // RQ3 RQ4

   // pin synchroniser
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         sync1 <= '1;
         sync2 <= '1;
      end
      else
      begin
         sync1 <= switch_input_i;
         sync2 <= sync1;
      end
   end
   // low pin means tied to the return line
   assign active = ~(sync2 ^ polarity); // RQ1 RQ2
   // tenth-second tick
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i || tick)
      begin
         tenth_cnt <= 32'h0000_0000;
      end
      else
      begin
         tenth_cnt <= tenth_cnt + 32'h0000_0001;
      end
   end
   assign tick = (tenth_cnt >= 32'(TENTH_CYCLES - 1));
   generate
      for (genvar i = 0; i < NUM_IN; i++)
      begin : g_in
         if (i < 3)
         begin : g_dly
            dtm_input_delay #(.DW(16)) u_dly (
               .clk_i   (clk_i),
               .nrst_i  (nrst_i),
               .level_i (active[i]),
               .tick_i  (tick),
               .delay_i (delay_time[i]),
               .level_o (recognised_input_o[i])
            ); // RQ5
         end
         else
         begin : g_pass
            dtm_input_delay #(.DW(16)) u_pass (
               .clk_i   (clk_i),
               .nrst_i  (nrst_i),
               .level_i (active[i]),
               .tick_i  (1'b0),
               .delay_i (16'h0000),
               .level_o (recognised_input_o[i])
            ); // RQ5
         end
      end
   endgenerate
   // sequencer cycle pulse
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         seq_cnt <= 32'h0000_0000;
      end
      else if (step_sequencer_cycle_done_i)
      begin
         seq_cnt <= 32'(SEQ_CYCLES); // RQ18
      end
      else if (seq_cnt != 32'h0000_0000)
      begin
         seq_cnt <= seq_cnt - 32'h0000_0001; // RQ18
      end
   end

   // status conditions by selector code
   assign cond[0]  = 1'b0; // RQ9
   assign cond[1]  = run_i; // RQ10
   assign cond[2]  = fault_stop_i; // RQ11
   assign cond[3]  = freq_level_flag_one_i; // RQ12
   assign cond[4]  = freq_reached_i; // RQ12
   assign cond[5]  = run_i && zero_freq_i; // RQ13
   assign cond[6]  = motor_overload_prewarn_i; // RQ14
   assign cond[7]  = drive_overload_10s_i; // RQ15
   assign cond[8]  = preset_count_reached_i; // RQ16
   assign cond[9]  = intermediate_count_reached_i; // RQ16
   assign cond[10] = length_exceeded_i; // RQ17
   assign cond[11] = (seq_cnt != 32'h0000_0000); // RQ18
   assign cond[12] = run_time_exceeded_i; // RQ19
   assign cond[13] = set_freq_beyond_limit_i && out_freq_at_limit_i; // RQ20

   function automatic logic pick(input dtm_sel_type sel, input logic [`DTM_NUM_SEL-1:0] c);
      pick = (sel < 8'(`DTM_NUM_SEL)) ? c[sel[3:0]] : 1'b0; // RQ23
   endfunction

   assign next_main     = pick(relay_function_sel, cond); // RQ8
   assign next_ext      = pick(extension_relay_function_sel, cond); // RQ8
   assign next_oc_level = pick(oc_output_function_sel, cond); // RQ8

   // fast pulse train, half period clamped to the rate limit
   assign half_eff = (pulse_half_period < MIN_HALF) ? MIN_HALF : pulse_half_period; // RQ7
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i || pulse_half_period == 16'h0000)
      begin
         pulse_cnt   <= 16'h0000;
         pulse_level <= 1'b0;
      end
      else if (pulse_cnt >= half_eff - 16'h0001)
      begin
         pulse_cnt   <= 16'h0000;
         pulse_level <= !pulse_level; // RQ7
      end
      else
      begin
         pulse_cnt <= pulse_cnt + 16'h0001;
      end
   end
   // registered output terminals
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         main_relay_o             <= 1'b0;
         extension_relay_two_o    <= 1'b0;
         shared_output_terminal_o <= 1'b0;
      end
      else
      begin
         main_relay_o          <= next_main; // RQ22
         extension_relay_two_o <= next_ext; // RQ22
         shared_output_terminal_o <= (shared_terminal_mode_sel == DTM_MODE_OC) ?
                                     next_oc_level : pulse_level; // RQ6
      end
   end
   // checks: cycles since the pulse train last toggled
   logic [15:0] since_tog;
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i || $changed(pulse_level))
      begin
         since_tog <= 16'h0000;
      end
      else if (since_tog != 16'hFFFF)
      begin
         since_tog <= since_tog + 16'h0001;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   a_pol_zero_tied: assert property ( // RQ1
      (!polarity[3] && !switch_input_i[3])[*4] |-> recognised_input_o[3])
      else $error("tied input with polarity 0 not active");
   a_pol_one_tied: assert property ( // RQ2
      (polarity[3] && !switch_input_i[3])[*4] |-> !recognised_input_o[3])
      else $error("tied input with polarity 1 active");
   a_word_reset: assert property (disable iff (1'b0) // RQ3
      !nrst_i |=> input_polarity_word_a == 20'h0_0000 && input_polarity_word_b == 4'h0)
      else $error("polarity words not cleared by reset");
   a_six_no_delay: assert property ( // RQ5
      (polarity[5] && switch_input_i[5])[*4] |-> recognised_input_o[5])
      else $error("input six delayed");
   a_oc_mode_out: assert property ( // RQ6
      shared_terminal_mode_sel == DTM_MODE_OC |=> shared_output_terminal_o == $past(next_oc_level))
      else $error("open-collector mode output wrong");
   a_pulse_rate: assert property ( // RQ7
      $changed(pulse_level) && $past(pulse_half_period) != 16'h0000
      |-> since_tog >= MIN_HALF - 16'h0001)
      else $error("pulse train above rate limit");
   a_sel_reset: assert property (disable iff (1'b0) // RQ8
      !nrst_i |=> relay_function_sel == 8'h02 && oc_output_function_sel == 8'h00)
      else $error("selector reset values wrong");
   a_sel_zero_off: assert property ( // RQ9
      relay_function_sel == 8'h00 |=> !main_relay_o)
      else $error("selector 0 drove output");
   a_run_follow: assert property ( // RQ10
      relay_function_sel == 8'h01 |=> main_relay_o == $past(run_i))
      else $error("run selector wrong");
   a_zero_stop_off: assert property ( // RQ13
      relay_function_sel == 8'h05 && !run_i |=> !main_relay_o)
      else $error("zero speed output on while stopped");
   a_seq_pulse_len: assert property ( // RQ18
      step_sequencer_cycle_done_i |=> seq_cnt == 32'(SEQ_CYCLES) ##1 cond[11])
      else $error("sequencer pulse not started");
   a_undef_off: assert property ( // RQ23
      relay_function_sel >= 8'h0E |=> !main_relay_o)
      else $error("undefined selector drove output");
   c_relay_on:  cover property ($rose(main_relay_o));
   c_pulse_tog: cover property ($rose(shared_output_terminal_o) && !shared_terminal_mode_sel);
   c_seq_pulse: cover property (step_sequencer_cycle_done_i ##1 cond[11]);
   c_in_seen:   cover property ($rose(recognised_input_o[0]) && delay_time[0] != 16'h0000);
endmodule

/* File: tb/dtm_field_model.sv */
// field wiring model: switch contacts between input pins and the return line
`timescale 1ns/1ps
module dtm_field_model
(
   input  wire logic [5:0] closed_i,
   output logic      [5:0] pin_o
);
   // open contact sits at the pull-up level, closed contact ties to return
   assign pin_o = ~closed_i;
endmodule

/* File: tb/test_dtm_terminal_map.sv */
// self-checking bench for the drive terminal io mapping block
`timescale 1ns/1ps
`include "dtm_params.svh"
module test_dtm_terminal_map;
   localparam int TC = 10;
   localparam int SC = 20;
   logic        clk_i;
   logic        nrst_i;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [5:0]  closed;
   logic [5:0]  pins;
   logic [5:0]  recog;
   logic [12:0] cond;
   logic        seq_done;
   logic        main_relay;
   logic        ext_relay;
   logic        shared_out;
   logic [31:0] q;
   logic [12:0] c;
   logic        e;
   int          err_count;
   int          n_checks;
   int          s;
   int          p;
   int          k;
   int          n;

   dtm_field_model fm (.closed_i(closed), .pin_o(pins));

   dtm_terminal_map #(.TENTH_CYCLES(TC), .SEQ_CYCLES(SC), .NUM_IN(6)) uut
   (
      .clk_i                        (clk_i),
      .nrst_i                       (nrst_i),
      .avs_address_i                (avs_address),
      .avs_read_i                   (avs_read),
      .avs_write_i                  (avs_write),
      .avs_writedata_i              (avs_writedata),
      .avs_readdata_o               (avs_readdata),
      .avs_waitrequest_o            (avs_waitrequest),
      .switch_input_i               (pins),
      .recognised_input_o           (recog),
      .run_i                        (cond[0]),
      .fault_stop_i                 (cond[1]),
      .freq_level_flag_one_i        (cond[2]),
      .freq_reached_i               (cond[3]),
      .zero_freq_i                  (cond[4]),
      .motor_overload_prewarn_i     (cond[5]),
      .drive_overload_10s_i         (cond[6]),
      .preset_count_reached_i       (cond[7]),
      .intermediate_count_reached_i (cond[8]),
      .length_exceeded_i            (cond[9]),
      .step_sequencer_cycle_done_i  (seq_done),
      .run_time_exceeded_i          (cond[10]),
      .set_freq_beyond_limit_i      (cond[11]),
      .out_freq_at_limit_i          (cond[12]),
      .main_relay_o                 (main_relay),
      .extension_relay_two_o        (ext_relay),
      .shared_output_terminal_o     (shared_out)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one avalon access, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do
      begin
         @(posedge clk_i);
         t++;
      end
      while (avs_waitrequest !== 1'b0 && t < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         err_count++;
         conclude();
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   function automatic logic exp_out(input int sel, input logic [12:0] v);
      case (sel)
         1: return v[0];
         2: return v[1];
         3: return v[2];
         4: return v[3];
         5: return v[0] & v[4];
         6: return v[5];
         7: return v[6];
         8: return v[7];
         9: return v[8];
         10: return v[9];
         12: return v[10];
         13: return v[11] & v[12];
         default: return 1'b0;
      endcase
   endfunction

   initial
   begin
      repeat (100000) @(posedge clk_i);
      err_count++;
      conclude();
   end

   initial
   begin
      nrst_i = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      closed = 6'h00;
      cond = 13'h0000;
      seq_done = 1'b0;
      err_count = 0;
      n_checks = 0;
      repeat (12) @(posedge clk_i);
      nrst_i <= 1'b1;
      // reset values and an unmapped place
      rd(`DTM_OFS_RELAY_SEL);
      check("relay sel", q, 32'h0000_0002);
      rd(`DTM_OFS_OC_SEL);
      check("oc sel", q, 32'h0000_0000);
      rd(`DTM_OFS_POL_A);
      check("pol a", q, 32'h0000_0000);
      rd(`DTM_OFS_POL_B);
      check("pol b", q, 32'h0000_0000);
      rd(`DTM_OFS_MODE);
      check("mode", q, 32'h0000_0000);
      rd(6'h3C);
      check("unmapped", q, 32'h0000_0000);
      // every selector against one-hot and all-on conditions
      wr(`DTM_OFS_MODE, 32'h0000_0001);
      for (s = 0; s < 16; s++)
      begin
         wr(`DTM_OFS_OC_SEL, 32'(s));
         wr(`DTM_OFS_RELAY_SEL, 32'(s));
         wr(`DTM_OFS_EXT_SEL, 32'(s));
         for (p = 0; p < 14; p++)
         begin
            c = (p == 13) ? 13'h1FFF : 13'h0001 << p;
            e = exp_out(s, c);
            @(posedge clk_i);
            cond <= c;
            @(posedge clk_i);
            @(negedge clk_i);
            check("main relay", 32'(main_relay), 32'(e));
            check("ext relay", 32'(ext_relay), 32'(e));
            check("shared oc", 32'(shared_out), 32'(e));
         end
      end
      @(posedge clk_i);
      cond <= 13'h0000;
      // sequencer cycle pulse width
      wr(`DTM_OFS_RELAY_SEL, 32'h0000_000B);
      @(posedge clk_i);
      seq_done <= 1'b1;
      @(posedge clk_i);
      seq_done <= 1'b0;
      n = 0;
      repeat (SC + 10)
      begin
         @(negedge clk_i);
         if (main_relay === 1'b1)
            n++;
      end
      check("seq pulse", 32'(n), 32'(SC));
      // polarity sense, open and closed contacts
      for (k = 0; k < 2; k++)
      begin
         wr(`DTM_OFS_POL_A, k ? 32'h0001_1111 : 32'h0000_0000);
         wr(`DTM_OFS_POL_B, 32'(k));
         for (p = 0; p < 2; p++)
         begin
            @(posedge clk_i);
            closed <= p ? 6'h3F : 6'h00;
            repeat (6) @(posedge clk_i);
            check("recognised", 32'(recog), (p ^ k) ? 32'h0000_003F : 32'h0000_0000);
         end
      end
      @(posedge clk_i);
      closed <= 6'h00;
      wr(`DTM_OFS_POL_B, 32'h0000_0000);
      for (k = 0; k < 5; k++)
      begin
         wr(`DTM_OFS_POL_A, 32'h0000_0001 << (4 * k));
         repeat (6) @(posedge clk_i);
         check("pol digit", 32'(recog), 32'h0000_0001 << k);
      end
      wr(`DTM_OFS_POL_A, 32'h0000_0000);
      wr(`DTM_OFS_POL_B, 32'hFFFF_FFFF);
      rd(`DTM_OFS_POL_B);
      check("pol b bits", q, 32'h0000_000F);
      repeat (6) @(posedge clk_i);
      check("input six", 32'(recog), 32'h0000_0020);
      wr(`DTM_OFS_POL_B, 32'h0000_0000);
      // state-change delay on input one only
      wr(`DTM_OFS_DELAY1, 32'h0000_FFFF);
      rd(`DTM_OFS_DELAY1);
      check("delay clamp", q, 32'h0000_8CA0);
      wr(`DTM_OFS_DELAY1, 32'h0000_0005);
      repeat (10) @(posedge clk_i);
      closed <= 6'h09;
      repeat (8) @(negedge clk_i);
      check("undelayed", 32'(recog[3]), 32'h0000_0001);
      check("delayed", 32'(recog[0]), 32'h0000_0000);
      n = 8;
      while (recog[0] !== 1'b1 && n < 80)
      begin
         @(negedge clk_i);
         n++;
      end
      check("delay time", 32'(n >= 4 * TC && n <= 5 * TC + 6), 32'h0000_0001);
      @(posedge clk_i);
      closed <= 6'h08;
      repeat (15) @(posedge clk_i);
      check("glitch held", 32'(recog[0]), 32'h0000_0001);
      closed <= 6'h09;
      repeat (70) @(posedge clk_i);
      check("glitch dropped", 32'(recog[0]), 32'h0000_0001);
      // pulse mode half period clamps to the 50 kHz floor
      wr(`DTM_OFS_MODE, 32'h0000_0000);
      wr(`DTM_OFS_HALF, 32'h0000_0001);
      n = 0;
      while (shared_out !== 1'b1 && n < 3000)
      begin
         @(negedge clk_i);
         n++;
      end
      k = 0;
      while (shared_out === 1'b1 && k < 3000)
      begin
         @(negedge clk_i);
         k++;
      end
      check("half period", 32'(k), 32'(`DTM_MIN_HALF));
      conclude();
   end
endmodule
